// >>> core/flash_write_latch_block_lock.sv
// Serial flash write-enable latch, volatile arming and per-block lock command logic.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Opcode 04h clears the write-enable latch at a clean frame end.
// - Program, erase and OTP writes are refused while the latch is clear; status writes are too unless armed.
// - Every byte shifts in over eight serial clocks, most significant bit first.
// - A frame ending off a byte boundary or incomplete changes nothing.
// - Write-disable and volatile-arm frames carry the opcode byte alone.
// - Opcode 50h arms a volatile status write without touching the latch.
// - Arming serves only the next status write, then is dropped.
// - Lock 36h carries a 24-bit address, top bit first, no data.
// - Unlock 39h uses the same opcode plus three address bytes format.
// - Valid lock or unlock updates the addressed bit, then clears the latch.
// - Lock and unlock are ignored unless the latch is set.
// - Lock bits protect only when per-block select is set; else range bits.
// - All lock bits come up set after reset.
// - Program and erase aimed at a locked block are refused.
// - Opcodes 3Ch and 3Dh behave identically as read-lock.
// - Read-lock takes opcode and address on SI, returns data on SO.
// - Read-lock byte has the lock bit in bit 0, repeated while selected.
// - Each lock bit covers the aligned 4 kB region holding the address.
// - Opcode 06h sets the write-enable latch at a clean frame end.
module flash_write_latch_block_lock (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   input wire logic per_block_protect_select,
   input wire logic range_protected,
   output logic write_enable_latch,
   output logic volatile_write_armed,
   output logic exec_pulse,
   output logic refuse_pulse,
   output logic [7:0] exec_opcode,
   output logic [flash_lock_pkg::ADDR_W-1:0] exec_addr,
   output logic exec_volatile
);
   import flash_lock_pkg::*;

   logic cs_s1, cs_s2, cs_s3;
   logic sclk_s1, sclk_s2, sclk_s3;
   logic si_s1, si_s2;
   logic frame_end, sclk_rise, sclk_fall;

   // Two-stage synchronisers, plus a third stage for edge finding on cs and sclk.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         si_s1 <= 1'b0;
         si_s2 <= 1'b0;
      end else begin
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         si_s1 <= si;
         si_s2 <= si_s1;
      end
   end

   // Edges are only honoured while the chip is selected, so idle level does not matter.
   assign frame_end = cs_s2 && !cs_s3;
   assign sclk_rise = !cs_s2 && sclk_s2 && !sclk_s3;
   assign sclk_fall = !cs_s2 && !sclk_s2 && sclk_s3;

   frame_state_type state_reg, state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [2:0] byte_cnt_reg, byte_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] opcode_reg, opcode_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic so_reg, so_next;
   logic wel_reg, wel_next;
   logic armed_reg, armed_next;
   logic [BLOCK_COUNT-1:0] lock_reg, lock_next;
   logic exec_reg, exec_next;
   logic refuse_reg, refuse_next;
   logic [7:0] exec_op_reg, exec_op_next;
   logic [ADDR_W-1:0] exec_addr_reg, exec_addr_next;
   logic exec_vol_reg, exec_vol_next;
   logic [BLOCK_IDX_W-1:0] blk_idx;
   logic lock_bit, aligned, is_read_lock, is_status, is_array_addr, is_chip, is_otp;
   logic blk_protected;

   // Address bits 21:12, just above the 4 kB offset, pick the lock bit; bits 23:22 are ignored.
   assign blk_idx = addr_reg[BLOCK_LSB+BLOCK_IDX_W-1:BLOCK_LSB];
   assign lock_bit = lock_reg[blk_idx];
   assign aligned = (bit_cnt_reg == 3'h0);
   assign is_read_lock = (opcode_reg == OP_READ_LOCK_A) || (opcode_reg == OP_READ_LOCK_B);
   assign is_status = (opcode_reg == OP_STATUS_WR_1) || (opcode_reg == OP_STATUS_WR_2) ||
                      (opcode_reg == OP_STATUS_WR_3) || (opcode_reg == OP_STATUS_WR_4);
   assign is_array_addr = (opcode_reg == OP_PROGRAM) || (opcode_reg == OP_PROGRAM_DUAL) ||
                          (opcode_reg == OP_PROGRAM_QUAD) || (opcode_reg == OP_PROGRAM_SEQ_A) ||
                          (opcode_reg == OP_PROGRAM_SEQ_B) || (opcode_reg == OP_ERASE_4K) ||
                          (opcode_reg == OP_ERASE_32K) || (opcode_reg == OP_ERASE_64K);
   assign is_chip = (opcode_reg == OP_ERASE_CHIP_A) || (opcode_reg == OP_ERASE_CHIP_B);
   assign is_otp = (opcode_reg == OP_PROGRAM_OTP);

   // Per-block bits guard the array only when selected; otherwise the range decode does.
   always_comb begin
      blk_protected = range_protected;
      if (per_block_protect_select) begin
         blk_protected = is_chip ? (|lock_reg) : lock_bit;
      end
   end

   // Serial shifter, frame sequencer and command execution at chip-select release.
   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      byte_cnt_next = byte_cnt_reg;
      shift_next = shift_reg;
      opcode_next = opcode_reg;
      addr_next = addr_reg;
      so_next = so_reg;
      wel_next = wel_reg;
      armed_next = armed_reg;
      lock_next = lock_reg;
      exec_next = 1'b0;
      refuse_next = 1'b0;
      exec_op_next = exec_op_reg;
      exec_addr_next = exec_addr_reg;
      exec_vol_next = exec_vol_reg;
      case (state_reg)
         ST_IDLE: begin
            bit_cnt_next = 3'h0;
            byte_cnt_next = 3'h0;
            if (!cs_s2) begin
               state_next = ST_SHIFT;
            end
         end
         ST_SHIFT, ST_READOUT: begin
            if (sclk_rise) begin
               shift_next = {shift_reg[6:0], si_s2};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if ((byte_cnt_reg != 3'h0) && (byte_cnt_reg < LEN_WITH_ADDR)) begin
                  addr_next = {addr_reg[ADDR_W-2:0], si_s2};
               end
               if (bit_cnt_reg == BIT_LAST) begin
                  if (byte_cnt_reg != LEN_SATURATE) begin
                     byte_cnt_next = byte_cnt_reg + 3'h1;
                  end
                  if (byte_cnt_reg == 3'h0) begin
                     opcode_next = {shift_reg[6:0], si_s2};
                  end
                  if ((byte_cnt_reg == LEN_WITH_ADDR - 3'h1) && is_read_lock) begin
                     state_next = ST_READOUT;
                  end
               end
            end
            // Only bit 0 of the repeating byte carries the lock state; the rest read zero.
            if (sclk_fall && (state_reg == ST_READOUT)) begin
               so_next = (bit_cnt_reg == BIT_LAST) && lock_bit;
            end
            if (frame_end) begin
               state_next = ST_IDLE;
               so_next = 1'b0;
               if (aligned) begin
                  if ((opcode_reg == OP_WRITE_ENABLE) && (byte_cnt_reg == LEN_OPCODE_ONLY)) begin
                     wel_next = 1'b1;
                  end
                  if ((opcode_reg == OP_WRITE_DISABLE) && (byte_cnt_reg == LEN_OPCODE_ONLY)) begin
                     wel_next = 1'b0;
                  end
                  if ((opcode_reg == OP_VOLATILE_ARM) && (byte_cnt_reg == LEN_OPCODE_ONLY)) begin
                     armed_next = 1'b1;
                  end
                  if (((opcode_reg == OP_BLOCK_LOCK) || (opcode_reg == OP_BLOCK_UNLOCK)) &&
                      (byte_cnt_reg == LEN_WITH_ADDR) && wel_reg) begin
                     lock_next[blk_idx] = (opcode_reg == OP_BLOCK_LOCK);
                     wel_next = 1'b0;
                  end
                  if (is_status && (byte_cnt_reg >= LEN_STATUS_MIN)) begin
                     armed_next = 1'b0;
                     exec_op_next = opcode_reg;
                     exec_addr_next = addr_reg;
                     exec_vol_next = armed_reg;
                     if (wel_reg || armed_reg) begin
                        exec_next = 1'b1;
                     end else begin
                        refuse_next = 1'b1;
                     end
                  end
                  if (((is_array_addr || is_otp) && (byte_cnt_reg >= LEN_WITH_ADDR)) ||
                      (is_chip && (byte_cnt_reg == LEN_OPCODE_ONLY))) begin
                     exec_op_next = opcode_reg;
                     exec_addr_next = addr_reg;
                     exec_vol_next = 1'b0;
                     if (!wel_reg || (!is_otp && blk_protected)) begin
                        refuse_next = 1'b1;
                     end else begin
                        exec_next = 1'b1;
                     end
                  end
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State registers; every lock bit starts set.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         opcode_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
         so_reg <= 1'b0;
         wel_reg <= 1'b0;
         armed_reg <= 1'b0;
         lock_reg <= LOCK_RESET;
         exec_reg <= 1'b0;
         refuse_reg <= 1'b0;
         exec_op_reg <= 8'h00;
         exec_addr_reg <= 24'h00_0000;
         exec_vol_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         byte_cnt_reg <= byte_cnt_next;
         shift_reg <= shift_next;
         opcode_reg <= opcode_next;
         addr_reg <= addr_next;
         so_reg <= so_next;
         wel_reg <= wel_next;
         armed_reg <= armed_next;
         lock_reg <= lock_next;
         exec_reg <= exec_next;
         refuse_reg <= refuse_next;
         exec_op_reg <= exec_op_next;
         exec_addr_reg <= exec_addr_next;
         exec_vol_reg <= exec_vol_next;
      end
   end

   // Output drive; SO is enabled only in the read-lock data phase.
   assign so = so_reg;
   assign so_oe_n = (state_reg != ST_READOUT);
   assign write_enable_latch = wel_reg;
   assign volatile_write_armed = armed_reg;
   assign exec_pulse = exec_reg;
   assign refuse_pulse = refuse_reg;
   assign exec_opcode = exec_op_reg;
   assign exec_addr = exec_addr_reg;
   assign exec_volatile = exec_vol_reg;

   logic clean_end;
   assign clean_end = frame_end && (state_reg != ST_IDLE) && aligned;

   // Checks on the latch, arming, lock bits and serial framing.
   a_wrdi_clears_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && (opcode_reg == OP_WRITE_DISABLE) && (byte_cnt_reg == LEN_OPCODE_ONLY)
      |=> !write_enable_latch) else $error("write disable left the latch set");
   a_wren_sets_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && (opcode_reg == OP_WRITE_ENABLE) && (byte_cnt_reg == LEN_OPCODE_ONLY)
      |=> write_enable_latch [*2]) else $error("write enable did not set the latch");
   a_guarded_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && !wel_reg && !armed_reg && (is_status || is_chip || is_array_addr || is_otp)
      |=> !exec_pulse) else $error("guarded command ran without the latch");
   a_bit_count_step: assert property (@(posedge clk_sys) disable iff (!rstn)
      sclk_rise && (state_reg != ST_IDLE) && !frame_end
      |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1) else $error("bit count did not advance");
   a_partial_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
      frame_end && !aligned
      |=> $stable(write_enable_latch) && $stable(lock_reg) && !exec_pulse && !refuse_pulse)
      else $error("misaligned frame changed state");
   a_arm_keeps_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && (opcode_reg == OP_VOLATILE_ARM) && (byte_cnt_reg == LEN_OPCODE_ONLY)
      |=> volatile_write_armed && (write_enable_latch == $past(wel_reg)))
      else $error("volatile arm misbehaved");
   a_arm_used_once: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && is_status && (byte_cnt_reg >= LEN_STATUS_MIN)
      |=> !volatile_write_armed && (exec_volatile == $past(armed_reg)))
      else $error("arming survived a status write");
   a_lock_update: assert property (@(posedge clk_sys) disable iff (!rstn)
      clean_end && wel_reg && (byte_cnt_reg == LEN_WITH_ADDR) &&
      ((opcode_reg == OP_BLOCK_LOCK) || (opcode_reg == OP_BLOCK_UNLOCK))
      |=> (lock_reg[$past(blk_idx)] == ($past(opcode_reg) == OP_BLOCK_LOCK)) &&
          !write_enable_latch) else $error("lock bit not updated");
   a_lock_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
      frame_end && !wel_reg |=> $stable(lock_reg)) else $error("lock changed without latch");
   a_so_released: assert property (@(posedge clk_sys) disable iff (!rstn)
      cs_s2 && cs_s3 |-> so_oe_n) else $error("SO driven while deselected");
   a_readout_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
      sclk_fall && (state_reg == ST_READOUT) && (bit_cnt_reg != BIT_LAST) |=> !so)
      else $error("upper read-lock bits not zero");
endmodule // flash_write_latch_block_lock
`default_nettype wire

// >>> core/flash_lock_pkg.sv
// Shared constants for the serial flash write-latch and block-lock logic.
package flash_lock_pkg;
   // Command opcodes.
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_VOLATILE_ARM = 8'h50;
   localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
   localparam logic [7:0] OP_READ_LOCK_A = 8'h3C;
   localparam logic [7:0] OP_READ_LOCK_B = 8'h3D;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_PROGRAM_DUAL = 8'hA2;
   localparam logic [7:0] OP_PROGRAM_QUAD = 8'h32;
   localparam logic [7:0] OP_PROGRAM_SEQ_A = 8'hAF;
   localparam logic [7:0] OP_PROGRAM_SEQ_B = 8'hAD;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
   localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_PROGRAM_OTP = 8'h9B;
   localparam logic [7:0] OP_STATUS_WR_1 = 8'h01;
   localparam logic [7:0] OP_STATUS_WR_2 = 8'h31;
   localparam logic [7:0] OP_STATUS_WR_3 = 8'h11;
   localparam logic [7:0] OP_STATUS_WR_4 = 8'h71;
   // Address and block geometry.
   localparam int ADDR_W = 24;
   localparam int BLOCK_LSB = 12;
   localparam int BLOCK_IDX_W = 10;
   localparam int BLOCK_COUNT = 1024;
   localparam logic [BLOCK_COUNT-1:0] LOCK_RESET = {BLOCK_COUNT{1'b1}};
   // Frame byte counts, opcode byte included, and the index of the last bit in a byte.
   localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
   localparam logic [2:0] LEN_STATUS_MIN = 3'h2;
   localparam logic [2:0] LEN_WITH_ADDR = 3'h4;
   localparam logic [2:0] LEN_SATURATE = 3'h5;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Frame sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_READOUT = 2'b10
   } frame_state_type;
endpackage

// >>> dv/spi_host_model.sv
// Host-side SPI master model that drives whole frames onto the serial link.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk_sys,
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   logic cpol;
   // The link idles deselected with the serial clock parked at its mode level.
   initial begin
      cpol = 1'b0;
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // Waits n system clocks and lands just after the last edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // Sends nbits of the word MSB first, then clocks rdbits more and collects SO.
   task automatic frame(input logic [39:0] bits, input int nbits, input int rdbits,
                        output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      step(1);
      sclk = cpol;
      cs_n = 1'b0;
      step(4);
      for (i = 0; i < nbits + rdbits; i++) begin
         sclk = 1'b0;
         si = (i < nbits) ? bits[39-i] : ~si;
         step(4);
         sclk = 1'b1;
         if (i >= nbits) rx = {rx[14:0], so};
         step(4);
      end
      sclk = cpol;
      step(4);
      cs_n = 1'b1;
      si = ~si;
      step(8);
   endtask
endmodule // spi_host_model
`default_nettype wire

// >>> dv/flash_write_latch_block_lock_test.sv
// Self-checking bench for the write-enable latch and block-lock command logic.
`timescale 1ns/1ps
`default_nettype none
module flash_write_latch_block_lock_test;
   import flash_lock_pkg::*;
   logic clk_sys, rstn, cs_n, sclk, si, so, so_oe_n, per_block_protect_select, range_protected;
   logic write_enable_latch, volatile_write_armed, exec_pulse, refuse_pulse, exec_volatile;
   logic [7:0] exec_opcode;
   logic [ADDR_W-1:0] exec_addr;
   int mismatches = 0, compares = 0, exec_count = 0, refuse_count = 0;
   logic [15:0] rx;
   flash_write_latch_block_lock DUT (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
      .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n),
      .per_block_protect_select(per_block_protect_select), .range_protected(range_protected),
      .write_enable_latch(write_enable_latch), .volatile_write_armed(volatile_write_armed),
      .exec_pulse(exec_pulse), .refuse_pulse(refuse_pulse), .exec_opcode(exec_opcode),
      .exec_addr(exec_addr), .exec_volatile(exec_volatile));
   spi_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
   // Clock of 25 ns.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Counts the one-cycle outcome pulses.
   always @(posedge clk_sys) begin
      if (exec_pulse === 1'b1) exec_count++;
      if (refuse_pulse === 1'b1) refuse_count++;
   end
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] op, input logic [23:0] addr, input int nbits);
      logic [15:0] r;
      host.frame({op, addr, 8'h00}, nbits, 0, r);
   endtask
   task automatic read_lock(input logic [7:0] op, input logic [23:0] addr);
      host.frame({op, addr, 8'h00}, 32, 16, rx);
   endtask
   task automatic report_and_stop();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic t_reset_state();
      check(24'(write_enable_latch), 24'h00_0000, "latch after reset");
      check(24'(volatile_write_armed), 24'h00_0000, "arming after reset");
      read_lock(OP_READ_LOCK_A, 24'h00_0000);
      check(24'(rx), 24'h00_0101, "lock byte block 0");
      read_lock(OP_READ_LOCK_B, 24'h3F_F000);
      check(24'(rx), 24'h00_0101, "lock byte top block");
      check(24'(so_oe_n), 24'h00_0001, "so released");
      $display("test reset_state done");
   endtask
   task automatic t_latch_cmds();
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      check(24'(write_enable_latch), 24'h00_0001, "latch set");
      send(OP_WRITE_DISABLE, 24'h00_0000, 8);
      check(24'(write_enable_latch), 24'h00_0000, "latch cleared");
      send(OP_WRITE_ENABLE, 24'h00_0000, 9);
      check(24'(write_enable_latch), 24'h00_0000, "off-boundary end");
      send(OP_WRITE_ENABLE, 24'h00_0000, 5);
      check(24'(write_enable_latch), 24'h00_0000, "short frame");
      send(OP_WRITE_ENABLE, 24'h00_0000, 16);
      check(24'(write_enable_latch), 24'h00_0000, "extra byte");
      host.cpol = 1'b1;
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      check(24'(write_enable_latch), 24'h00_0001, "mode 3 set");
      send(OP_WRITE_DISABLE, 24'h00_0000, 8);
      check(24'(write_enable_latch), 24'h00_0000, "mode 3 clear");
      host.cpol = 1'b0;
      $display("test latch_cmds done");
   endtask
   task automatic t_block_lock();
      send(OP_BLOCK_UNLOCK, 24'h01_2345, 32);
      read_lock(OP_READ_LOCK_A, 24'h01_2000);
      check(24'(rx), 24'h00_0101, "unlock without latch");
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      send(OP_BLOCK_UNLOCK, 24'h01_2345, 32);
      check(24'(write_enable_latch), 24'h00_0000, "latch after unlock");
      read_lock(OP_READ_LOCK_B, 24'h01_2FFF);
      check(24'(rx), 24'h00_0000, "unlocked region");
      read_lock(OP_READ_LOCK_A, 24'h01_3000);
      check(24'(rx), 24'h00_0101, "neighbour region");
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      send(OP_BLOCK_UNLOCK, 24'h01_3000, 24);
      read_lock(OP_READ_LOCK_A, 24'h01_3000);
      check(24'(rx), 24'h00_0101, "short unlock");
      send(OP_BLOCK_LOCK, 24'h01_2ABC, 32);
      check(24'(write_enable_latch), 24'h00_0000, "latch after lock");
      read_lock(OP_READ_LOCK_A, 24'h01_2000);
      check(24'(rx), 24'h00_0101, "relocked region");
      $display("test block_lock done");
   endtask
   task automatic t_program();
      per_block_protect_select = 1'b1;
      range_protected = 1'b1;
      send(OP_PROGRAM, 24'h0A_0010, 40);
      check(24'(refuse_count), 24'h00_0001, "program without latch");
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      send(OP_BLOCK_UNLOCK, 24'h0A_0000, 32);
      send(OP_WRITE_ENABLE, 24'h00_0000, 8);
      send(OP_PROGRAM, 24'h0A_0010, 40);
      check(24'(exec_count), 24'h00_0001, "program unlocked");
      check(exec_addr, 24'h0A_0010, "program address");
      send(OP_ERASE_4K, 24'h0B_0000, 32);
      check(24'(refuse_count), 24'h00_0002, "erase locked");
      check(24'(exec_opcode), 24'h00_0020, "refused opcode");
      per_block_protect_select = 1'b0;
      range_protected = 1'b0;
      send(OP_ERASE_4K, 24'h0B_0000, 32);
      check(24'(exec_count), 24'h00_0002, "range governs");
      // The lock bit still reads set although the erase ran, so it is no protection verdict.
      read_lock(OP_READ_LOCK_A, 24'h0B_0000);
      check(24'(rx), 24'h00_0101, "lock byte is not protection");
      range_protected = 1'b1;
      send(OP_ERASE_4K, 24'h0A_0000, 32);
      check(24'(refuse_count), 24'h00_0003, "range protects");
      $display("test program done");
   endtask
   task automatic t_volatile();
      send(OP_WRITE_DISABLE, 24'h00_0000, 8);
      send(OP_VOLATILE_ARM, 24'h00_0000, 8);
      check(24'(volatile_write_armed), 24'h00_0001, "armed");
      check(24'(write_enable_latch), 24'h00_0000, "latch untouched");
      send(OP_STATUS_WR_1, 24'hA5_0000, 16);
      check(24'(exec_count), 24'h00_0003, "volatile write runs");
      check(24'(exec_volatile), 24'h00_0001, "volatile used");
      check(24'(volatile_write_armed), 24'h00_0000, "arming dropped");
      send(OP_STATUS_WR_1, 24'hA5_0000, 16);
      check(24'(refuse_count), 24'h00_0004, "second write refused");
      send(OP_VOLATILE_ARM, 24'h00_0000, 9);
      check(24'(volatile_write_armed), 24'h00_0000, "arm off boundary");
      $display("test volatile done");
   endtask
   // Main sequence after a five-cycle reset.
   initial begin
      rstn = 1'b0;
      per_block_protect_select = 1'b0;
      range_protected = 1'b0;
      repeat (5) @(posedge clk_sys);
      #2;
      rstn = 1'b1;
      host.step(3);
      t_reset_state();
      t_latch_cmds();
      t_block_lock();
      t_program();
      t_volatile();
      report_and_stop();
   end
   // Watchdog well beyond the expected 0.19 ms of traffic.
   initial begin
      #1_000_000;
      mismatches++;
      $display("ERROR at %0t ns: watchdog expired", $time);
      report_and_stop();
   end
endmodule // flash_write_latch_block_lock_test
`default_nettype wire
